/* common/tone_port_pkg.sv */
// Purpose: Shared constants for the tone command host port.
// Assumes: System clock of 10 MHz, one byte lane in use.
// Notes: Wishbone register map and byte encodings live here.
package tone_port_pkg;
  // ----
  // Clock and timing
  // ----
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned ALIVE_MS = 10;
  // Longest time between alive toggles, rounded down to whole cycles.
  localparam int unsigned ALIVE_CYCLES = (CLK_HZ / 1000) * ALIVE_MS;
  // Toggle at half the allowed interval to keep clear margin.
  localparam int unsigned ALIVE_HALF = ALIVE_CYCLES / 2;
  localparam int unsigned SYSCLK_DIV = 4;
  localparam int unsigned CLKDIV_W = 2;
  // ----
  // Wishbone register map (byte addresses)
  // ----
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_RET = 4'hc;
  // Control register fields.
  localparam int unsigned CTRL_FMT_BIT = 0;
  localparam int unsigned CTRL_SERIAL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status register fields.
  localparam int unsigned ST_CMD_VALID_BIT = 0;
  localparam int unsigned ST_RET_PENDING_BIT = 1;
  localparam int unsigned ST_FMT_ERR_BIT = 2;
  // ----
  // Byte encodings
  // ----
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned CHAN_BIT = 6;
  localparam logic FMT_TWO_OF_SIX = 1'b0;
  localparam logic FMT_BINARY = 1'b1;
  localparam logic [7:0] READY_BYTE = 8'h00;
  localparam logic [3:0] CODE_TONE_OFF = 4'h0;
  localparam logic [3:0] CODE_START_PAIR = 4'hd;
  // Frequency masks, bit 5 is the top tone down to bit 0 the bottom tone.
  localparam logic [5:0] FREQ_700 = 6'h01;
  localparam logic [5:0] FREQ_900 = 6'h02;
  localparam logic [5:0] FREQ_1100 = 6'h04;
  localparam logic [5:0] FREQ_1300 = 6'h08;
  localparam logic [5:0] FREQ_1500 = 6'h10;
  localparam logic [5:0] FREQ_1700 = 6'h20;
endpackage

/* verilog/strobe_sync.sv */
// Purpose: Two-stage synchroniser with rise and fall detection.
// Assumes: Input is asynchronous to clk_sys_i.
// Notes: Resets to the idle-high level.
`timescale 1ns/1ps
`default_nettype none
module strobe_sync (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Only sync_reg reads the first stage; edges come from later stages.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges are decoded from settled stages only.
  assign level_o = sync_reg;
  assign fall_o = prev_reg & ~sync_reg;
  assign rise_o = ~prev_reg & sync_reg;
endmodule
`default_nettype wire

/* verilog/tone_codec.sv */
// Purpose: Converts between binary tone codes and two-of-six masks.
// Assumes: Pure combinational logic.
// Notes: Invalid masks return the tone-off code.
`timescale 1ns/1ps
`default_nettype none
module tone_codec (
  input wire logic [3:0] code_i,
  input wire logic [5:0] mask_i,
  output logic [5:0] mask_o,
  output logic [3:0] code_o
);
  // --------------------------------------------------------------------
  // Code table
  // --------------------------------------------------------------------
  function automatic logic [5:0] code_to_mask(input logic [3:0] c);
    case (c)
      4'h1: code_to_mask = tone_port_pkg::FREQ_700 | tone_port_pkg::FREQ_900;
      4'h2: code_to_mask = tone_port_pkg::FREQ_700 | tone_port_pkg::FREQ_1100;
      4'h3: code_to_mask = tone_port_pkg::FREQ_900 | tone_port_pkg::FREQ_1100;
      4'h4: code_to_mask = tone_port_pkg::FREQ_700 | tone_port_pkg::FREQ_1300;
      4'h5: code_to_mask = tone_port_pkg::FREQ_900 | tone_port_pkg::FREQ_1300;
      4'h6: code_to_mask = tone_port_pkg::FREQ_1100 | tone_port_pkg::FREQ_1300;
      4'h7: code_to_mask = tone_port_pkg::FREQ_700 | tone_port_pkg::FREQ_1500;
      4'h8: code_to_mask = tone_port_pkg::FREQ_900 | tone_port_pkg::FREQ_1500;
      4'h9: code_to_mask = tone_port_pkg::FREQ_1100 | tone_port_pkg::FREQ_1500;
      4'ha: code_to_mask = tone_port_pkg::FREQ_1300 | tone_port_pkg::FREQ_1500;
      4'hb: code_to_mask = tone_port_pkg::FREQ_700 | tone_port_pkg::FREQ_1700;
      4'hc: code_to_mask = tone_port_pkg::FREQ_900 | tone_port_pkg::FREQ_1700;
      4'hd: code_to_mask = tone_port_pkg::FREQ_1100 | tone_port_pkg::FREQ_1700;
      4'he: code_to_mask = tone_port_pkg::FREQ_1300 | tone_port_pkg::FREQ_1700;
      4'hf: code_to_mask = tone_port_pkg::FREQ_1500 | tone_port_pkg::FREQ_1700;
      default: code_to_mask = 6'h00;
    endcase
  endfunction

  // Reverse lookup scans the table; unmatched masks read as tone off.
  always_comb begin
    code_o = tone_port_pkg::CODE_TONE_OFF;
    for (int i = 1; i < 16; i++) begin
      if (code_to_mask(4'(i)) == mask_i) begin
        code_o = 4'(i);
      end
    end
  end

  assign mask_o = code_to_mask(code_i);
endmodule
`default_nettype wire

/* verilog/tone_command_host_port.sv */
// Purpose: Host byte port of a dual-channel tone signalling transceiver.
// Assumes: clk_sys_i is the internal clock at 10 MHz; strobes are async.
// Notes: Tone engines sit behind the Wishbone side of this block.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: System clock output runs at one quarter of the internal clock.
// RULE2: Two-of-six bytes: bit7 direction, bit6 channel, bits5-0 frequency flags.
// RULE3: Outbound-full flag tells the host a byte waits to be read.
// RULE4: Inbound-empty flag tells the host whether the last write was consumed.
// RULE5: Host ties the byte-select input low; only the low lane is used.
// RULE6: While read strobe is low, the outbound byte drives the data lines.
// RULE7: Host raises read strobe after capture, ending the data drive.
// RULE8: Host writes by lowering write strobe, presenting data, then raising it.
// RULE9: The inbound latch captures the data lines on write strobe rising.
// RULE10: Host holds reset low at least five system clock cycles.
// RULE11: In reset both strobes count as high and data lines float.
// RULE12: In reset the serial clock and transmit outputs float.
// RULE13: The alive output toggles at least every 10 ms while running.
// RULE14: Supervisor should reset the device if alive stops toggling for 10 ms.
// RULE15: Host ties both mode straps low for coprocessor port mode.
// RULE16: Binary bytes: bit7 direction, bit6 channel, bits5-4 zero, bits3-0 code.
// RULE17: Code 0 is tone off, 1-10 digits, 11-15 special signal pairs.
// RULE18: Inbound-empty rises on write strobe fall, falls once consumed.
// RULE19: Host waits for inbound-empty low before the next write.
// RULE20: Outbound-full falls when a tone is detected, rises on read strobe low.
// RULE21: A configuration bit selects binary (1) or two-of-six (0) format.
module tone_command_host_port (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host port pins.
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic latch_byte_select_i,
  input wire logic [7:0] latch_data_lines_i,
  output logic [7:0] latch_data_lines_o,
  output logic latch_data_lines_oe_n_o,
  output logic outbound_latch_full_flag_o,
  output logic inbound_latch_empty_flag_o,
  // Clock, alive and serial enables.
  output logic system_clock_out_o,
  output logic alive_toggle_o,
  output logic serial_clock_oe_n_o,
  output logic serial_tx_oe_n_o
);
  // ----
  // Strobe synchronisers
  // ----
  logic rd_lvl;
  logic rd_fall;
  logic rd_rise;
  logic wr_lvl;
  logic wr_fall;
  logic wr_rise;
  logic [7:0] din_meta_reg;
  logic [7:0] din_sync_reg;
  logic bsel_meta_reg;
  logic bsel_sync_reg;

  // Under reset the synchronisers hold high, so both strobes read idle.
  strobe_sync u_rd_sync ( // see RULE11
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(rd_n_i),
    .level_o(rd_lvl),
    .fall_o(rd_fall),
    .rise_o(rd_rise)
  );

  strobe_sync u_wr_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(wr_n_i),
    .level_o(wr_lvl),
    .fall_o(wr_fall),
    .rise_o(wr_rise)
  );

  // Data lines pass two flops; they line up with the synchronised strobe.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
      bsel_meta_reg <= 1'b1;
      bsel_sync_reg <= 1'b1;
    end else begin
      din_meta_reg <= latch_data_lines_i;
      din_sync_reg <= din_meta_reg;
      bsel_meta_reg <= latch_byte_select_i;
      bsel_sync_reg <= bsel_meta_reg;
    end
  end

  // ----
  // Wishbone decode
  // ----
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr_req = req & wb_we_i & wb_sel_i[0];
  wire logic hit_ctrl = wb_adr_i == tone_port_pkg::ADDR_CTRL;
  wire logic hit_status = wb_adr_i == tone_port_pkg::ADDR_STATUS;
  wire logic hit_cmd = wb_adr_i == tone_port_pkg::ADDR_CMD;
  wire logic hit_ret = wb_adr_i == tone_port_pkg::ADDR_RET;
  wire logic fmt_bin = ctrl_reg[tone_port_pkg::CTRL_FMT_BIT];

  // ----
  // Inbound latch: host command bytes
  // ----
  logic [7:0] in_latch_reg;
  logic in_empty_reg;
  logic cmd_valid_reg;
  logic fmt_err_reg;
  wire logic cmd_consume = req & ~wb_we_i & hit_cmd;
  wire logic cmd_is_cmd = din_sync_reg[tone_port_pkg::DIR_BIT];
  wire logic bin_pad_bad = fmt_bin & (din_sync_reg[5:4] != 2'b00);

  // Capture on strobe rise; a new write wins over a read in the same cycle.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_latch_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
      fmt_err_reg <= 1'b0;
    end else if (wr_rise) begin
      in_latch_reg <= din_sync_reg; // see RULE9
      cmd_valid_reg <= 1'b1;
      fmt_err_reg <= ~cmd_is_cmd | bin_pad_bad; // see RULE16
    end else if (cmd_consume) begin
      cmd_valid_reg <= 1'b0;
    end
  end

  // Empty flag rises at strobe fall and clears once the engine takes the byte.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_empty_reg <= 1'b0;
    end else if (wr_fall) begin
      in_empty_reg <= 1'b1; // see RULE18
    end else if (cmd_consume & ~wr_rise & wr_lvl) begin
      in_empty_reg <= 1'b0; // see RULE4
    end
  end

  // Decoded command fields; both formats map to a channel and a mask.
  logic [5:0] cmd_mask_bin;
  logic [3:0] ret_code_unused;
  tone_codec u_cmd_codec ( // see RULE17
    .code_i(in_latch_reg[3:0]),
    .mask_i(6'h00),
    .mask_o(cmd_mask_bin),
    .code_o(ret_code_unused)
  );
  wire logic [5:0] cmd_mask = fmt_bin ? cmd_mask_bin : in_latch_reg[5:0]; // see RULE21
  wire logic cmd_chan = in_latch_reg[tone_port_pkg::CHAN_BIT]; // see RULE2

  // ----
  // Outbound latch: detected tone reports
  // ----
  logic [7:0] out_latch_reg;
  logic out_full_n_reg;
  logic ret_pending_reg;
  logic [5:0] ret_mask_in;
  logic [3:0] ret_code;
  logic [5:0] ret_mask_unused;
  wire logic ret_load = wr_req & hit_ret;
  wire logic ret_chan = wb_dat_i[tone_port_pkg::CHAN_BIT];
  assign ret_mask_in = wb_dat_i[5:0];

  tone_codec u_ret_codec (
    .code_i(4'h0),
    .mask_i(ret_mask_in),
    .mask_o(ret_mask_unused),
    .code_o(ret_code)
  );

  // Engine supplies a channel and frequency mask; encoding follows format.
  wire logic [7:0] ret_byte = fmt_bin ?
    {1'b0, ret_chan, 2'b00, ret_code} : // see RULE16
    {1'b0, ret_chan, ret_mask_in}; // see RULE2

  // After reset a ready byte of zero waits for the host, flag low.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_latch_reg <= tone_port_pkg::READY_BYTE;
      out_full_n_reg <= 1'b0;
      ret_pending_reg <= 1'b1;
    end else if (ret_load) begin
      out_latch_reg <= ret_byte;
      out_full_n_reg <= 1'b0; // see RULE20
      ret_pending_reg <= 1'b1; // see RULE3
    end else if (rd_fall) begin
      out_full_n_reg <= 1'b1; // see RULE20
      ret_pending_reg <= 1'b0;
    end
  end

  // ----
  // Data line drive
  // ----
  logic [7:0] dout_reg;
  logic dout_oe_n_reg;

  // Drive only while read is low; byte select is assumed low by the host.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_reg <= 8'h00;
      dout_oe_n_reg <= 1'b1; // see RULE11
    end else begin
      dout_reg <= out_latch_reg;
      dout_oe_n_reg <= rd_lvl | bsel_sync_reg; // see RULE6, RULE7, RULE5
    end
  end

  // ----
  // Control register and read mux
  // ----
  assign ctrl_next = (wr_req & hit_ctrl) ? wb_dat_i[1:0] : ctrl_reg;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_next[1:0] = ctrl_reg;
    end else if (hit_status) begin
      rdata_next[tone_port_pkg::ST_CMD_VALID_BIT] = cmd_valid_reg;
      rdata_next[tone_port_pkg::ST_RET_PENDING_BIT] = ret_pending_reg;
      rdata_next[tone_port_pkg::ST_FMT_ERR_BIT] = fmt_err_reg;
    end else if (hit_cmd) begin
      rdata_next[7:0] = in_latch_reg;
      rdata_next[8] = cmd_chan;
      rdata_next[14:9] = cmd_mask;
    end else if (hit_ret) begin
      rdata_next[7:0] = out_latch_reg;
    end
  end

  // One-cycle answer; unmapped addresses still ack and read zero.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= tone_port_pkg::CTRL_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= req;
      rdata_reg <= req ? rdata_next : rdata_reg;
    end
  end

  // ----
  // Clock output, alive toggle and serial enables
  // ----
  logic [tone_port_pkg::CLKDIV_W-1:0] div_reg;
  logic system_clock_out_reg;
  logic [19:0] alive_cnt_reg;
  logic alive_reg;
  logic ser_clk_oe_n_reg;
  logic ser_tx_oe_n_reg;
  wire logic alive_wrap = alive_cnt_reg == 20'(tone_port_pkg::ALIVE_HALF - 1);

  // Divide by four: output flips every second cycle.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= '0;
      system_clock_out_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      system_clock_out_reg <= div_reg[0] ? ~system_clock_out_reg : system_clock_out_reg; // see RULE1
    end
  end

  // Toggle every 5 ms, well inside the 10 ms limit a supervisor checks.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alive_cnt_reg <= 20'h00000;
      alive_reg <= 1'b0;
    end else begin
      alive_cnt_reg <= alive_wrap ? 20'h00000 : alive_cnt_reg + 20'h00001;
      alive_reg <= alive_wrap ? ~alive_reg : alive_reg; // see RULE13, RULE14
    end
  end

  // Serial outputs float in reset and until software enables them.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ser_clk_oe_n_reg <= 1'b1; // see RULE12
      ser_tx_oe_n_reg <= 1'b1;
    end else begin
      ser_clk_oe_n_reg <= ~ctrl_reg[tone_port_pkg::CTRL_SERIAL_EN_BIT];
      ser_tx_oe_n_reg <= ~ctrl_reg[tone_port_pkg::CTRL_SERIAL_EN_BIT];
    end
  end

  // Every output is a flop.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign latch_data_lines_o = dout_reg;
  assign latch_data_lines_oe_n_o = dout_oe_n_reg;
  assign outbound_latch_full_flag_o = out_full_n_reg;
  assign inbound_latch_empty_flag_o = in_empty_reg;
  assign system_clock_out_o = system_clock_out_reg;
  assign alive_toggle_o = alive_reg;
  assign serial_clock_oe_n_o = ser_clk_oe_n_reg;
  assign serial_tx_oe_n_o = ser_tx_oe_n_reg;
endmodule
`default_nettype wire

/* dv/tone_port_properties.sv */
// Purpose: Concurrent checks on the host port, bus and clock pins.
// Assumes: One clock domain; strobes reach the core through two flops.
// Notes: Strobe responses get one cycle of slack around the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tone_port_properties (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] latch_data_lines_o,
  input wire logic latch_data_lines_oe_n_o,
  input wire logic outbound_latch_full_flag_o,
  input wire logic inbound_latch_empty_flag_o,
  input wire logic system_clock_out_o,
  input wire logic alive_toggle_o
);
  // ----
  // Helper logic
  // ----
  logic [2:0] up_reg;
  logic [16:0] quiet_reg;
  logic alive_last_reg;
  wire logic cmd_rd = wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i == tone_port_pkg::ADDR_CMD);
  // Settle count hides the divider start-up; quiet count times the alive pin.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_reg <= 3'h0;
      quiet_reg <= 17'h0;
      alive_last_reg <= 1'b0;
    end else begin
      up_reg <= (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
      alive_last_reg <= alive_toggle_o;
      quiet_reg <= (alive_toggle_o != alive_last_reg) ? 17'h0 : quiet_reg + 17'h1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // A quarter-rate square wave holds each level for exactly two samples.
  sequence s_half;
    ##1 $stable(system_clock_out_o) ##1 $changed(system_clock_out_o);
  endsequence
  sequence s_drive;
    ##[2:4] (!latch_data_lines_oe_n_o && outbound_latch_full_flag_o);
  endsequence
  property p_clk_div;
    (up_reg > 3'h3) && $changed(system_clock_out_o) |-> s_half;
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("clock output rate wrong");
  property p_clk_live;
    (up_reg > 3'h3) && $stable(system_clock_out_o) |=> $changed(system_clock_out_o);
  endproperty
  a_clk_live: assert property (p_clk_live) else $error("clock output stalled");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus answer late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer too long");
  property p_rd_drive;
    $fell(rd_n_i) |-> s_drive;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read not answered");
  property p_rd_hold;
    !latch_data_lines_oe_n_o && !rd_n_i |=> !latch_data_lines_oe_n_o && $stable(latch_data_lines_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte not held");
  property p_rd_end;
    $rose(rd_n_i) |-> ##[2:4] latch_data_lines_oe_n_o;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("data drive not ended");
  property p_wr_flag;
    $fell(wr_n_i) |-> ##[2:4] inbound_latch_empty_flag_o;
  endproperty
  a_wr_flag: assert property (p_wr_flag) else $error("inbound flag not raised");
  property p_in_hold;
    inbound_latch_empty_flag_o && !cmd_rd && !$past(cmd_rd) |=> inbound_latch_empty_flag_o;
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("inbound flag fell early");
  property p_out_hold;
    !outbound_latch_full_flag_o && rd_n_i |=> !outbound_latch_full_flag_o;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outbound flag lost");
  property p_alive;
    quiet_reg < tone_port_pkg::ALIVE_CYCLES;
  endproperty
  a_alive: assert property (p_alive) else $error("alive output stuck");
endmodule
bind tone_command_host_port tone_port_properties tone_port_properties_i (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .latch_data_lines_o(latch_data_lines_o),
  .latch_data_lines_oe_n_o(latch_data_lines_oe_n_o),
  .outbound_latch_full_flag_o(outbound_latch_full_flag_o),
  .inbound_latch_empty_flag_o(inbound_latch_empty_flag_o),
  .system_clock_out_o(system_clock_out_o), .alive_toggle_o(alive_toggle_o)
);
`default_nettype wire

/* dv/host_model.sv */
// Purpose: Behavioural host processor on the strobed byte port.
// Assumes: Called from the bench; signals change just after rising edges.
// Notes: A released data wire shows the inverse of the last byte driven.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] dut_data_i,
  input wire logic dut_oe_n_i,
  input wire logic full_flag_i,
  input wire logic empty_flag_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic byte_select_o,
  output logic [7:0] data_o,
  output logic fault_o
);
  logic [7:0] drive;
  // Only the low lane exists, so the select pin stays low.
  initial begin
    {rd_n_o, wr_n_o, byte_select_o, fault_o, drive} = {4'b1100, 8'h5a};
  end
  // The wire carries the device byte while it drives, else the host pattern.
  assign data_o = dut_oe_n_i ? drive : dut_data_i;
  task automatic wait_sig(input int which, input logic want);
    int n;
    for (n = 0; n < 40; n++) begin
      if ((which == 0 ? full_flag_i : which == 1 ? empty_flag_i : dut_oe_n_i) === want) break;
      @(posedge clk_sys_i);
    end
    if (n == 40) fault_o = 1'b1;
  endtask
  task automatic write_byte(input logic [7:0] b);
    wait_sig(1, 1'b0);
    @(posedge clk_sys_i);
    {wr_n_o, drive} <= {1'b0, b};
    wait_sig(1, 1'b1);
    repeat (4) @(posedge clk_sys_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    drive <= ~b;
  endtask
  task automatic read_byte(input int slow, output logic [7:0] b);
    wait_sig(0, 1'b0);
    @(posedge clk_sys_i);
    rd_n_o <= 1'b0;
    wait_sig(2, 1'b0);
    repeat (slow) @(posedge clk_sys_i);
    b = data_o;
    rd_n_o <= 1'b1;
    wait_sig(2, 1'b1);
  endtask
  task automatic set_rd(input logic v);
    @(posedge clk_sys_i);
    rd_n_o <= v;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Self-checking bench for the tone command host port.
// Assumes: Host model on the strobed port, bench tasks on the bus side.
// Notes: Binary returns are written as masks and read back as codes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, nrst_n, cyc, stb, we, ack, rd_n, wr_n, bsel, oe_n, full, empty;
  logic clk_out, alive, sc_oe_n, tx_oe_n, fault;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0] bus, dut_byte, b;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  tone_command_host_port tone_command_host_port_i (.clk_sys_i(clk_sys), .nrst_i(nrst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .latch_byte_select_i(bsel), .latch_data_lines_i(bus), .latch_data_lines_o(dut_byte),
    .latch_data_lines_oe_n_o(oe_n), .outbound_latch_full_flag_o(full),
    .inbound_latch_empty_flag_o(empty), .system_clock_out_o(clk_out),
    .alive_toggle_o(alive), .serial_clock_oe_n_o(sc_oe_n), .serial_tx_oe_n_o(tx_oe_n));
  host_model host_model_i (.clk_sys_i(clk_sys), .dut_data_i(dut_byte), .dut_oe_n_i(oe_n),
    .full_flag_i(full), .empty_flag_i(empty), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .byte_select_o(bsel), .data_o(bus), .fault_o(fault));
  // ----
  // Clock, timeout and helpers
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The alive wait dominates the run, so the ceiling sits well above it.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      stop_test();
    end
  end
  function automatic logic [5:0] mask_of(input logic [3:0] c);
    logic [5:0] t [16];
    t = '{6'h00, 6'h03, 6'h05, 6'h06, 6'h09, 6'h0a, 6'h0c, 6'h11, 6'h12, 6'h14, 6'h18,
          6'h21, 6'h22, 6'h24, 6'h28, 6'h30};
    return t[c];
  endfunction
  function automatic logic [7:0] ret_byte(input logic f, input logic ch, input logic [3:0] c);
    return f ? {2'b00 | ch, 2'b00, c} : {1'b0, ch, mask_of(c)};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int k;
    @(posedge clk_sys);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    chk("bus ack", ack, 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // One command in and one return out, in the chosen format.
  task automatic round(input logic f, input logic [3:0] c);
    logic ch;
    logic [7:0] cmd;
    logic [7:0] got;
    logic [31:0] r;
    ch = 1'($urandom);
    cmd = f ? {1'b1, ch, 2'b00, c} : {1'b1, ch, mask_of(c)};
    host_model_i.write_byte(cmd);
    chk("inbound flag set", empty, 1'b1);
    wb(1'b0, tone_port_pkg::ADDR_CMD, 32'h0, 4'h1, r);
    chk("command", r[14:0], {mask_of(c), ch, cmd});
    repeat (2) @(posedge clk_sys);
    chk("inbound flag clear", empty, 1'b0);
    wb(1'b1, tone_port_pkg::ADDR_RET, {25'h0, ch, mask_of(c)}, 4'h1, r);
    repeat (2) @(posedge clk_sys);
    chk("outbound flag", full, 1'b0);
    host_model_i.read_byte($urandom % 4, got);
    chk("return", got, ret_byte(f, ch, c));
  endtask
  task automatic stop_test();
    chk("host fault", fault, 1'b0);
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(83487));
    {nrst_n, cyc, stb, we, adr, sel, wdat} = '0;
    repeat (6) @(posedge clk_sys);
    chk("data oe_n in reset", oe_n, 1'b1);
    chk("serial oe_n in reset", {sc_oe_n, tx_oe_n}, 2'h3);
    chk("flags in reset", {full, empty}, 2'h0);
    nrst_n <= 1'b1;
    $display("test reset finished");
    host_model_i.read_byte(0, b);
    chk("ready byte", b, tone_port_pkg::READY_BYTE);
    chk("outbound flag after read", full, 1'b1);
    n = 0;
    repeat (40) begin
      b[0] = clk_out;
      @(posedge clk_sys);
      if (clk_out !== b[0]) n++;
    end
    chk("clock output edges", n, 20);
    wb(1'b0, tone_port_pkg::ADDR_CTRL, 32'h0, 4'h1, q);
    chk("ctrl reset", q[1:0], tone_port_pkg::CTRL_RESET);
    wb(1'b1, tone_port_pkg::ADDR_CTRL, 32'h3, 4'h0, q);
    wb(1'b0, tone_port_pkg::ADDR_CTRL, 32'h0, 4'h1, q);
    chk("ctrl masked write", q[1:0], 2'h0);
    wb(1'b0, 4'h2, 32'h0, 4'h1, q);
    chk("unmapped read", q, 32'h0);
    $display("test start finished");
    repeat (6) round(1'b0, 4'(1 + $urandom % 15));
    $display("test two_of_six finished");
    wb(1'b1, tone_port_pkg::ADDR_CTRL, 32'h3, 4'h1, q);
    for (int c = 0; c < 16; c++) round(1'b1, 4'(c));
    chk("serial oe_n enabled", {sc_oe_n, tx_oe_n}, 2'h0);
    $display("test binary finished");
    host_model_i.set_rd(1'b0);
    nrst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("data oe_n in reset", oe_n, 1'b1);
    chk("serial oe_n in reset", {sc_oe_n, tx_oe_n}, 2'h3);
    host_model_i.set_rd(1'b1);
    @(posedge clk_sys);
    nrst_n <= 1'b1;
    $display("test second reset finished");
    b[0] = alive;
    for (n = 0; n <= tone_port_pkg::ALIVE_CYCLES && alive === b[0]; n++) @(posedge clk_sys);
    chk("alive in time", n <= tone_port_pkg::ALIVE_CYCLES, 1'b1);
    $display("test alive finished");
    stop_test();
  end
endmodule
`default_nettype wire
